// ==== lrs_reset_states.sv ====
// Reset output states, post-reset configuration and display RAM writes
`timescale 1ns/1ps
// How it works
// - In reset, shared seg/com pins are segment outputs at lowest drive level.
// - Display technique command picks segment or common role for each shared pin.
// - In reset, shared scan/port pins are general outputs driven low.
// - Port state command picks scan or general role for each shared pin.
// - Key request stays released during reset and until port state command.
// - Power-on reset initialises everything but the display RAM, with the display off.
// - Technique choosing 1/8 duty sets 1/8 duty and 1/4 bias.
// - Increment mode writes store code then advance address by one.
// - Reset clears key data and disables scanning until port state command.
// - Key held for 4800 periods pulls request low; reading clears it.
module lrs_reset_states #(
  parameter int KEY_HOLD = lrs_pkg::KEY_HOLD_PERIODS
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // Technique command: duty code and shared pin roles (1 = common)
  input  wire logic                          tech_wr,
  input  wire lrs_pkg::lrs_duty_type         tech_duty,
  input  wire logic                          tech_pin_a_com,
  input  wire logic                          tech_pin_b_com,
  // Port state command: roles (1 = scan), port levels, scan enables
  input  wire logic                          port_wr,
  input  wire logic                          port_a_scan,
  input  wire logic                          port_b_scan,
  input  wire logic                          port_a_level,
  input  wire logic                          port_b_level,
  // Display on/off command
  input  wire logic                          disp_wr,
  input  wire logic                          disp_on,
  // Display RAM writes
  input  wire logic                          ac_wr,
  input  wire logic [lrs_pkg::DISPLAY_CODE_RAM_AW-1:0]  ac_addr,
  input  wire logic                          display_code_ram_wr,
  input  wire logic                          display_code_ram_incr,
  input  wire logic [lrs_pkg::CODE_W-1:0]    display_code_ram_code,
  input  wire logic [lrs_pkg::DISPLAY_CODE_RAM_AW-1:0]  display_code_ram_rd_addr,
  output logic      [lrs_pkg::CODE_W-1:0]    display_code_ram_rd_data,
  // Key scan interface
  input  wire logic [lrs_pkg::N_KEY-1:0]     key_pressed,
  input  wire logic                          osc_tick,
  input  wire logic                          key_read,
  output logic      [lrs_pkg::N_KEY-1:0]     key_data,
  output logic                               key_scan_en,
  // Open-drain key request: low enable means pulled low
  output logic                               key_req_o,
  output logic                               key_req_oe_n,
  // Driver state outputs
  output logic                               display_on,
  output lrs_pkg::lrs_duty_type              duty,
  output logic      [1:0]                    bias,
  output logic                               pin_a_is_com,
  output logic                               pin_b_is_com,
  output logic      [2:0]                    seg_level,
  output logic      [2:0]                    com_level,
  output logic      [2:0]                    shared_seg_com_pin_a,
  output logic      [2:0]                    shared_seg_com_pin_b,
  output logic                               pin_a_is_scan,
  output logic                               pin_b_is_scan,
  output logic                               scan_or_gp_pin_a,
  output logic                               scan_or_gp_pin_b,
  output logic      [lrs_pkg::N_SCAN-1:0]    dedicated_scan_outputs
);
  initial begin
    if (KEY_HOLD < 1 || KEY_HOLD >= (1 << lrs_pkg::KEY_CNT_W)) $error("KEY_HOLD out of range");
  end

  // Configuration state
  logic                  tech_done_q, tech_done_d;
  logic                  port_done_q, port_done_d;
  logic                  disp_q, disp_d;
  lrs_pkg::lrs_duty_type duty_q, duty_d;
  logic                  a_com_q, a_com_d, b_com_q, b_com_d;
  logic                  a_scan_q, a_scan_d, b_scan_q, b_scan_d;
  logic                  a_lvl_q, a_lvl_d, b_lvl_q, b_lvl_d;

  // Next configuration from commands
  always_comb begin
    tech_done_d = tech_done_q;
    port_done_d = port_done_q;
    disp_d      = disp_q;
    duty_d      = duty_q;
    a_com_d     = a_com_q;
    b_com_d     = b_com_q;
    a_scan_d    = a_scan_q;
    b_scan_d    = b_scan_q;
    a_lvl_d     = a_lvl_q;
    b_lvl_d     = b_lvl_q;
    if (tech_wr) begin
      tech_done_d = 1'b1;
      duty_d      = tech_duty;
      a_com_d     = tech_pin_a_com;
      b_com_d     = tech_pin_b_com;
    end
    if (port_wr) begin
      port_done_d = 1'b1;
      a_scan_d    = port_a_scan;
      b_scan_d    = port_b_scan;
      a_lvl_d     = port_a_level;
      b_lvl_d     = port_b_level;
    end
    if (disp_wr) begin
      disp_d = disp_on;
    end
  end

  // Configuration registers, reset to safe display-off state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tech_done_q <= 1'b0;
      port_done_q <= 1'b0;
      disp_q      <= 1'b0;
      duty_q      <= lrs_pkg::LRS_DUTY_8;
      a_com_q     <= 1'b0;
      b_com_q     <= 1'b0;
      a_scan_q    <= 1'b0;
      b_scan_q    <= 1'b0;
      a_lvl_q     <= 1'b0;
      b_lvl_q     <= 1'b0;
    end else begin
      tech_done_q <= tech_done_d;
      port_done_q <= port_done_d;
      disp_q      <= disp_d;
      duty_q      <= duty_d;
      a_com_q     <= a_com_d;
      b_com_q     <= b_com_d;
      a_scan_q    <= a_scan_d;
      b_scan_q    <= b_scan_d;
      a_lvl_q     <= a_lvl_d;
      b_lvl_q     <= b_lvl_d;
    end
  end

  // Driver outputs: all levels at lowest level whether the display is on or off
  assign display_on    = disp_q;
  assign duty          = duty_q;
  assign bias          = lrs_pkg::BIAS_QUARTER;
  assign pin_a_is_com  = a_com_q;
  assign pin_b_is_com  = b_com_q;
  assign seg_level     = lrs_pkg::LOWEST_LCD_DRIVE_LEVEL;
  assign com_level     = lrs_pkg::LOWEST_LCD_DRIVE_LEVEL;
  assign shared_seg_com_pin_a = lrs_pkg::LOWEST_LCD_DRIVE_LEVEL;
  assign shared_seg_com_pin_b = lrs_pkg::LOWEST_LCD_DRIVE_LEVEL;
  assign pin_a_is_scan = a_scan_q;
  assign pin_b_is_scan = b_scan_q;

  // Address counter for display RAM
  logic [lrs_pkg::DISPLAY_CODE_RAM_AW-1:0] addr_q, addr_d;
  always_comb begin
    addr_d = addr_q;
    if (ac_wr) begin
      addr_d = ac_addr;
    end else if (display_code_ram_wr && display_code_ram_incr) begin
      addr_d = addr_q + 6'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addr_q <= lrs_pkg::DISPLAY_CODE_RAM_ADDR_RST;
    end else begin
      addr_q <= addr_d;
    end
  end

  lrs_display_code_ram u_display_code_ram (
    .sys_clk (sys_clk),
    .wr_en   (display_code_ram_wr),
    .wr_addr (addr_q),
    .wr_data (display_code_ram_code),
    .rd_addr (display_code_ram_rd_addr),
    .rd_data (display_code_ram_rd_data)
  );

  // Key request state machine
  lrs_pkg::lrs_key_type           kst_q, kst_d;
  logic [lrs_pkg::KEY_CNT_W-1:0]  kcnt_q, kcnt_d;
  logic [lrs_pkg::N_KEY-1:0]      kdat_q, kdat_d;
  logic                           any_key;
  assign any_key = |key_pressed;

  always_comb begin
    kst_d  = kst_q;
    kcnt_d = kcnt_q;
    kdat_d = kdat_q;
    case (kst_q)
      lrs_pkg::LRS_KEY_OFF: begin
        if (port_wr) begin
          kst_d = lrs_pkg::LRS_KEY_IDLE;
        end
      end
      lrs_pkg::LRS_KEY_IDLE: begin
        kcnt_d = '0;
        if (any_key) begin
          kst_d = lrs_pkg::LRS_KEY_HOLD;
        end
      end
      lrs_pkg::LRS_KEY_HOLD: begin
        if (!any_key) begin
          kst_d = lrs_pkg::LRS_KEY_IDLE;
        end else if (osc_tick) begin
          kcnt_d = kcnt_q + 13'h0001;
          if (32'(kcnt_q) + 1 >= KEY_HOLD) begin
            kst_d  = lrs_pkg::LRS_KEY_REQ;
            kdat_d = key_pressed;
          end
        end
      end
      lrs_pkg::LRS_KEY_REQ: begin
        if (key_read) begin
          kst_d = lrs_pkg::LRS_KEY_IDLE;
        end
      end
      default: kst_d = lrs_pkg::LRS_KEY_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      kst_q  <= lrs_pkg::LRS_KEY_OFF;
      kcnt_q <= '0;
      kdat_q <= '0;
    end else begin
      kst_q  <= kst_d;
      kcnt_q <= kcnt_d;
      kdat_q <= kdat_d;
    end
  end

  assign key_data     = kdat_q;
  assign key_scan_en  = port_done_q;
  assign key_req_o    = 1'b0;
  assign key_req_oe_n = (kst_q != lrs_pkg::LRS_KEY_REQ);

  // Shared scan/port pins: scan role drives high when scanning enabled
  assign scan_or_gp_pin_a = a_scan_q ? port_done_q : a_lvl_q;
  assign scan_or_gp_pin_b = b_scan_q ? port_done_q : b_lvl_q;
  assign dedicated_scan_outputs = {lrs_pkg::N_SCAN{port_done_q}};
endmodule // lrs_reset_states

// ==== lrs_pkg.sv ====
// Package: constants and types for the LCD reset and output state block
package lrs_pkg;
  // Drive level codes for LCD driver outputs (0 = lowest level)
  localparam logic [2:0] LOWEST_LCD_DRIVE_LEVEL = 3'h0;
  // Display RAM geometry
  localparam int         DISPLAY_CODE_RAM_DEPTH            = 52;
  localparam int         DISPLAY_CODE_RAM_AW               = 6;
  localparam int         CODE_W                 = 8;
  localparam logic [5:0] DISPLAY_CODE_RAM_ADDR_RST         = 6'h00;
  // Segment, common and scan counts
  localparam int         N_SEG                  = 63;
  localparam int         N_COM                  = 8;
  localparam int         N_SCAN                 = 4;
  localparam int         N_KEY                  = 30;
  // Key hold time in oscillator periods before request
  localparam int         KEY_HOLD_PERIODS       = 4800;
  localparam int         KEY_CNT_W              = 13;
  // Duty selection codes
  typedef enum logic [1:0] {
    LRS_DUTY_8  = 2'b00,
    LRS_DUTY_9  = 2'b01,
    LRS_DUTY_10 = 2'b10
  } lrs_duty_type;
  // Bias code: 1/4 bias for all duties
  localparam logic [1:0] BIAS_QUARTER           = 2'h2;
  // Key request state machine
  typedef enum logic [1:0] {
    LRS_KEY_OFF  = 2'b00,
    LRS_KEY_IDLE = 2'b01,
    LRS_KEY_HOLD = 2'b10,
    LRS_KEY_REQ  = 2'b11
  } lrs_key_type;
endpackage

// ==== lrs_display_code_ram.sv ====
// Display code RAM with registered read data
`timescale 1ns/1ps
module lrs_display_code_ram #(
  parameter int DEPTH = lrs_pkg::DISPLAY_CODE_RAM_DEPTH,
  parameter int AW    = lrs_pkg::DISPLAY_CODE_RAM_AW,
  parameter int DW    = lrs_pkg::CODE_W
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  initial begin
    if (DEPTH > (1 << AW)) $error("lrs_display_code_ram: depth exceeds address range");
  end
  logic [DW-1:0] mem [DEPTH];
  // Write port and registered read
  always_ff @(posedge sys_clk) begin
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (32'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
  end
endmodule // lrs_display_code_ram

// ==== lrs_checker_asserts.sv ====
// Checker of reset states and command effects at the ports
`timescale 1ns/1ps
module lrs_checker (
  input wire logic                         sys_clk,
  input wire logic                         nrst,
  input wire logic                         tech_wr,
  input wire lrs_pkg::lrs_duty_type        tech_duty,
  input wire logic                         tech_pin_a_com,
  input wire logic                         port_wr,
  input wire logic                         port_a_scan,
  input wire logic                         key_read,
  input wire logic                         key_req_oe_n,
  input wire logic [lrs_pkg::N_KEY-1:0]    key_data,
  input wire logic                         key_scan_en,
  input wire logic                         display_on,
  input wire lrs_pkg::lrs_duty_type        duty,
  input wire logic [1:0]                   bias,
  input wire logic                         pin_a_is_com,
  input wire logic                         pin_a_is_scan,
  input wire logic [2:0]                   shared_seg_com_pin_a,
  input wire logic [lrs_pkg::N_SCAN-1:0]   dedicated_scan_outputs
);
  logic port_seen_q;
  logic port_seen_d;
  // Remembers that a port command was taken
  always_comb port_seen_d = nrst & (port_seen_q | port_wr);
  always_ff @(posedge sys_clk) port_seen_q <= port_seen_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Request steps: raised, then answered by a read
  sequence s_req_new; key_req_oe_n ##1 !key_req_oe_n; endsequence
  sequence s_req_read; !key_req_oe_n && key_read; endsequence
  a_rst_state: assert property (!$past(nrst) |-> !display_on && duty == lrs_pkg::LRS_DUTY_8
    && !pin_a_is_com && !pin_a_is_scan && dedicated_scan_outputs == 4'h0) else $error("reset state wrong");
  a_tech_role: assert property (tech_wr |=> pin_a_is_com == $past(tech_pin_a_com))
    else $error("shared pin role wrong");
  a_tech_duty: assert property (tech_wr |=> duty == $past(tech_duty) && bias == lrs_pkg::BIAS_QUARTER)
    else $error("duty or bias wrong");
  a_port_role: assert property (port_wr |=> pin_a_is_scan == $past(port_a_scan) && key_scan_en)
    else $error("port role wrong");
  a_req_early: assert property (!port_seen_q |-> key_req_oe_n && key_data == '0 && !key_scan_en)
    else $error("key logic active before port command");
  a_req_clear: assert property (s_req_read |=> key_req_oe_n)
    else $error("request not cleared by read");
  a_req_cause: assert property (s_req_new |-> key_scan_en && key_data != '0)
    else $error("request without key data");
  a_pin_level: assert property (shared_seg_com_pin_a == lrs_pkg::LOWEST_LCD_DRIVE_LEVEL)
    else $error("shared pin level wrong");
endmodule // lrs_checker
bind lrs_reset_states lrs_checker lrs_checker_inst (.*);

// ==== lrs_host.sv ====
// Controller model: oscillator ticks and key data reads
`timescale 1ns/1ps
module lrs_host (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic poke,
  input  wire logic key_req_oe_n,
  output logic      osc_tick,
  output logic      key_read
);
  logic [1:0] tick_q = 2'h0;
  logic [2:0] wait_q = 3'h0;
  logic       rd_q = 1'b0;
  assign key_read = rd_q | poke;
  // Tick every third cycle; read once the request is seen, six cycles later when slow
  always @(posedge sys_clk) begin
    tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
    osc_tick <= (tick_q == 2'h2);
    if (!nrst || key_req_oe_n || rd_q) begin
      rd_q <= 1'b0;
      wait_q <= 3'h0;
    end else begin
      rd_q <= (wait_q == (slow ? 3'h6 : 3'h0));
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule // lrs_host

// ==== lrs_reset_states_test.sv ====
// Self-checking bench for the reset state block
`timescale 1ns/1ps
module lrs_reset_states_test;
  localparam int KH = 4;
  logic sys_clk, nrst, tech_wr, tech_pin_a_com, tech_pin_b_com, port_wr, port_a_scan, port_b_scan;
  logic port_a_level, port_b_level, disp_wr, disp_on, ac_wr, display_code_ram_wr, display_code_ram_incr, osc_tick, key_read;
  logic key_scan_en, key_req_o, key_req_oe_n, display_on, pin_a_is_com, pin_b_is_com, pin_a_is_scan;
  logic pin_b_is_scan, scan_or_gp_pin_a, scan_or_gp_pin_b, slow, poke;
  lrs_pkg::lrs_duty_type tech_duty, duty;
  logic [5:0]  ac_addr, display_code_ram_rd_addr, a, s;
  logic [7:0]  display_code_ram_code, display_code_ram_rd_data, mem [64];
  logic [29:0] key_pressed, key_data, k;
  logic [1:0]  bias;
  logic [2:0]  seg_level, com_level, shared_seg_com_pin_a, shared_seg_com_pin_b;
  logic [3:0]  dedicated_scan_outputs;
  logic [31:0] rng = 32'h0001055e;
  int error_cnt = 0, n_checks = 0, cyc = 0, ticks = 0, t0, w;
  lrs_reset_states #(.KEY_HOLD(KH)) lrs_reset_states_inst (.*);
  lrs_host lrs_host_inst (.*);
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [5:0] next_addr(logic [5:0] x);
    return x + 6'h01;
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst_chk();
    chk("disp", 0, display_on);
    chk("duty", lrs_pkg::LRS_DUTY_8, duty);
    chk("roles", 0, {pin_a_is_com, pin_b_is_com, pin_a_is_scan, pin_b_is_scan});
    chk("gp", 0, {scan_or_gp_pin_a, scan_or_gp_pin_b, dedicated_scan_outputs});
    chk("lvl", {4{lrs_pkg::LOWEST_LCD_DRIVE_LEVEL}}, {seg_level, com_level, shared_seg_com_pin_a, shared_seg_com_pin_b});
    chk("keys", 1, {key_data, key_scan_en, key_req_oe_n});
    chk("req_o", 0, key_req_o);
  endtask
  // Clock and hang guard
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    ticks <= ticks + int'(osc_tick === 1'b1); // Unknown tick before first edge counts as none
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {nrst, tech_wr, tech_pin_a_com, tech_pin_b_com, port_wr, port_a_scan, port_b_scan} = '0;
    {port_a_level, port_b_level, disp_wr, disp_on, ac_wr, display_code_ram_wr, display_code_ram_incr, slow, poke} = '0;
    {ac_addr, display_code_ram_rd_addr, display_code_ram_code, key_pressed} = '0;
    tech_duty = lrs_pkg::LRS_DUTY_8;
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    #1 rst_chk();
    // Key pressed and read attempted before any port command
    @(posedge sys_clk) key_pressed <= rnd() | 1;
    repeat (30) @(posedge sys_clk);
    poke <= 1;
    @(posedge sys_clk) poke <= 0;
    repeat (3) @(posedge sys_clk);
    #1 chk("early", 1, {key_data, key_req_oe_n});
    @(posedge sys_clk) key_pressed <= 0;
    $display("test early keys done");
    for (int d = 0; d < 3; d++) begin
      @(posedge sys_clk) {tech_pin_a_com, tech_pin_b_com} <= rnd();
      tech_duty <= lrs_pkg::lrs_duty_type'(d);
      tech_wr <= 1;
      @(posedge sys_clk) tech_wr <= 0;
      #1 chk("tech", {tech_duty, lrs_pkg::BIAS_QUARTER, tech_pin_a_com, tech_pin_b_com}, {duty, bias, pin_a_is_com, pin_b_is_com});
    end
    $display("test technique done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {port_a_level, port_b_level} <= rnd();
      {port_b_scan, port_a_scan} <= i;
      port_wr <= 1;
      @(posedge sys_clk) port_wr <= 0;
      #1 chk("port", {port_a_scan, port_b_scan, 1'b1}, {pin_a_is_scan, pin_b_is_scan, key_scan_en});
      chk("scan", 4'hf, dedicated_scan_outputs);
      if (!port_a_scan) chk("gp_a", port_a_level, scan_or_gp_pin_a);
      if (!port_b_scan) chk("gp_b", port_b_level, scan_or_gp_pin_b);
    end
    $display("test port done");
    s = rnd() % 40;
    a = s;
    @(posedge sys_clk) ac_addr <= s;
    ac_wr <= 1;
    for (int j = 0; j < 8; j++) begin
      @(posedge sys_clk) {ac_wr, display_code_ram_wr, display_code_ram_incr} <= {2'b01, j != 3};
      display_code_ram_code <= rnd();
      #1 mem[a] = display_code_ram_code;
      if (j != 3) a = next_addr(a);
    end
    @(posedge sys_clk) display_code_ram_wr <= 0;
    for (logic [5:0] r = s; r != a; r++) begin
      @(posedge sys_clk) display_code_ram_rd_addr <= r;
      @(posedge sys_clk) #1 chk("ram", mem[r], display_code_ram_rd_data);
    end
    $display("test ram done");
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk) slow <= (p == 0);
      k = rnd() | 1;
      key_pressed <= k;
      t0 = ticks;
      for (w = 0; key_req_oe_n && w < 500; w++) @(posedge sys_clk) #1;
      chk("hold", 1, ticks - t0 >= KH);
      chk("kdata", k, key_data);
      for (w = 0; !key_req_oe_n && w < 20; w++) @(posedge sys_clk) #1;
      chk("clear", 1, key_req_oe_n);
      @(posedge sys_clk) key_pressed <= 0;
    end
    $display("test key request done");
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) disp_on <= i;
      disp_wr <= 1;
      @(posedge sys_clk) disp_wr <= 0;
      #1 chk("disp_on", i, display_on);
    end
    $display("test display done");
    @(posedge sys_clk) nrst <= 0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    #1 rst_chk();
    $display("test second reset done");
    close_out();
  end
endmodule // lrs_reset_states_test
